// file: src/sas_exec.sv
// Subtract-and-sleep execution block with Avalon-MM register access
//
// Local design decisions: the address map and the Avalon-MM slave port.
`default_nettype none
`include "sas_params.svh"

module sas_exec #(
  parameter int DATA_W = 8,
  parameter int FILE_DEPTH = 128,
  parameter int FILE_AW = 7
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic wake_req,
  output logic osc_run,
  output logic wdt_clear
);

  // ==========================================================================
  // Subtraction: returns {no_borrow, nibble_no_borrow, difference}
  function automatic logic [DATA_W+1:0] sas_sub(input logic [DATA_W-1:0] minu,
                                                input logic [DATA_W-1:0] subt);
    logic [DATA_W:0] full;
    logic [4:0] low;
    full = {1'b0, minu} - {1'b0, subt};
    low = {1'b0, minu[3:0]} - {1'b0, subt[3:0]};
    // Borrow out is the top bit; carry is its inverse
    return {~full[DATA_W], ~low[4], full[DATA_W-1:0]};
  endfunction

  // ==========================================================================
  // State
  sas_pkg::sas_state_t state_ff;
  sas_pkg::sas_state_t nxt_state;
  logic [DATA_W-1:0] acc_ff;
  logic carry_ff;
  logic nibble_carry_ff;
  logic zero_ff;
  logic timeout_status_flag_ff;
  logic powerdown_status_flag_ff;
  logic osc_run_ff;
  logic wdt_clear_ff;
  logic wait_ff;
  logic [31:0] readdata_ff;
  logic [13:0] instr_ff;
  logic [FILE_AW-1:0] op_addr_ff;
  logic op_dest_ff;

  // ==========================================================================
  // Bus decode
  logic is_idle;
  logic mem_sel;
  logic accept_new;
  logic rd_reg_new;
  logic rd_mem_new;
  logic wr_fire;
  logic instr_fire;
  logic [13:0] wd_instr;
  logic literal_minus_accumulator_op;
  logic register_minus_accumulator_op;
  logic sleep_op;
  logic wake_hit;
  logic [31:0] reg_rdata;

  assign is_idle = (state_ff == sas_pkg::sas_st_idle);
  assign mem_sel = (avs_address >= `SAS_OFS_FILE);
  // Requests are only taken while no operation is in flight
  assign accept_new = (avs_read | avs_write) & wait_ff & is_idle;
  assign rd_reg_new = accept_new & avs_read & ~mem_sel;
  assign rd_mem_new = accept_new & avs_read & mem_sel;
  // A write takes effect at the edge where waitrequest is seen low
  assign wr_fire = avs_write & ~wait_ff;
  assign instr_fire = wr_fire & (avs_address == `SAS_OFS_INSTR) & (&avs_byteenable[1:0]);
  assign wd_instr = avs_writedata[13:0];

  // Instructions issued while asleep are dropped: the core clock is stopped
  assign literal_minus_accumulator_op = instr_fire & osc_run_ff
                                        & (wd_instr[13:9] == `SAS_OPC_SUBL);
  assign register_minus_accumulator_op = instr_fire & osc_run_ff
                                         & (wd_instr[13:8] == `SAS_OPC_SUBF);
  assign sleep_op = instr_fire & osc_run_ff & (wd_instr == `SAS_OPC_SLEEP);
  assign wake_hit = wake_req
                    | (wr_fire & (avs_address == `SAS_OFS_WAKE) & avs_byteenable[0]
                       & avs_writedata[0]);

  // ==========================================================================
  // File memory port: operand fetch, write-back, or bus access
  logic [FILE_AW-1:0] mem_addr;
  logic mem_we;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] mem_rdata;
  logic [DATA_W+1:0] lit_res;
  logic [DATA_W+1:0] reg_res;

  assign lit_res = sas_sub(avs_writedata[DATA_W-1:0], acc_ff);
  assign reg_res = sas_sub(mem_rdata, acc_ff);

  always_comb begin
    if (state_ff == sas_pkg::sas_st_op_ex) begin
      mem_addr = op_addr_ff;
    end else if (register_minus_accumulator_op) begin
      mem_addr = wd_instr[FILE_AW-1:0];
    end else begin
      mem_addr = avs_address[FILE_AW+1:2];
    end
  end

  // Write-back when the destination bit is one
  assign mem_we = ((state_ff == sas_pkg::sas_st_op_ex) & op_dest_ff)
                  | (wr_fire & mem_sel & avs_byteenable[0]);
  assign mem_wdata = (state_ff == sas_pkg::sas_st_op_ex) ? reg_res[DATA_W-1:0]
                                                         : avs_writedata[DATA_W-1:0];

  sas_file_ram #(
    .DATA_W(DATA_W),
    .DEPTH(FILE_DEPTH),
    .AW(FILE_AW)
  ) u_file_ram (
    .clk(clk),
    .arst_n(arst_n),
    .addr(mem_addr),
    .we(mem_we),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // ==========================================================================
  // Register read mux; unmapped offsets read as zero
  always_comb begin
    reg_rdata = 32'h0000_0000;
    unique case (avs_address)
      `SAS_OFS_ACC: reg_rdata[DATA_W-1:0] = acc_ff;
      `SAS_OFS_STATUS: begin
        reg_rdata[`SAS_ST_CARRY] = carry_ff;
        reg_rdata[`SAS_ST_NIBBLE] = nibble_carry_ff;
        reg_rdata[`SAS_ST_ZERO] = zero_ff;
        reg_rdata[`SAS_ST_PDOWN] = powerdown_status_flag_ff;
        reg_rdata[`SAS_ST_TOUT] = timeout_status_flag_ff;
        reg_rdata[`SAS_ST_ASLEEP] = ~osc_run_ff;
      end
      `SAS_OFS_INSTR: reg_rdata[13:0] = instr_ff;
      default: reg_rdata = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      sas_pkg::sas_st_idle: begin
        if (rd_mem_new) begin
          nxt_state = sas_pkg::sas_st_bus_rd;
        end else if (register_minus_accumulator_op) begin
          nxt_state = sas_pkg::sas_st_op_ex;
        end
      end
      sas_pkg::sas_st_bus_rd: nxt_state = sas_pkg::sas_st_idle;
      sas_pkg::sas_st_op_ex: nxt_state = sas_pkg::sas_st_idle;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= sas_pkg::sas_st_idle;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================================
  // Bus handshake; waitrequest stays low for exactly one cycle per request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_ff <= 1'b1;
      readdata_ff <= 32'h0000_0000;
    end else if (!wait_ff) begin
      wait_ff <= 1'b1;
    end else if (state_ff == sas_pkg::sas_st_bus_rd) begin
      readdata_ff <= {{(32-DATA_W){1'b0}}, mem_rdata};
      wait_ff <= 1'b0;
    end else if (rd_reg_new) begin
      readdata_ff <= reg_rdata;
      wait_ff <= 1'b0;
    end else if (accept_new & avs_write) begin
      wait_ff <= 1'b0;
    end
  end

  // Last issued instruction and operand address of a pending register op
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      instr_ff <= `SAS_RST_INSTR;
      op_addr_ff <= '0;
      op_dest_ff <= 1'b0;
    end else if (instr_fire) begin
      instr_ff <= wd_instr;
      op_addr_ff <= wd_instr[FILE_AW-1:0];
      op_dest_ff <= wd_instr[FILE_AW];
    end
  end

  // ==========================================================================
  // Accumulator
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_ff <= `SAS_RST_ACC;
    end else if (literal_minus_accumulator_op) begin
      acc_ff <= lit_res[DATA_W-1:0];
    end else if ((state_ff == sas_pkg::sas_st_op_ex) & ~op_dest_ff) begin
      acc_ff <= reg_res[DATA_W-1:0];
    end else if (wr_fire & (avs_address == `SAS_OFS_ACC) & avs_byteenable[0]) begin
      acc_ff <= avs_writedata[DATA_W-1:0];
    end
  end

  // Arithmetic flags; an executing subtraction wins over a software write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      carry_ff <= 1'b0;
      nibble_carry_ff <= 1'b0;
      zero_ff <= 1'b0;
    end else if (literal_minus_accumulator_op) begin
      carry_ff <= lit_res[DATA_W+1];
      nibble_carry_ff <= lit_res[DATA_W];
      zero_ff <= (lit_res[DATA_W-1:0] == '0);
    end else if (state_ff == sas_pkg::sas_st_op_ex) begin
      carry_ff <= reg_res[DATA_W+1];
      nibble_carry_ff <= reg_res[DATA_W];
      zero_ff <= (reg_res[DATA_W-1:0] == '0);
    end else if (wr_fire & (avs_address == `SAS_OFS_STATUS) & avs_byteenable[0]) begin
      carry_ff <= avs_writedata[`SAS_ST_CARRY];
      nibble_carry_ff <= avs_writedata[`SAS_ST_NIBBLE];
      zero_ff <= avs_writedata[`SAS_ST_ZERO];
    end
  end

  // ==========================================================================
  // Power-down: status flags, watchdog clear and oscillator gate
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timeout_status_flag_ff <= `SAS_RST_TOUT;
      powerdown_status_flag_ff <= `SAS_RST_PDOWN;
    end else if (sleep_op) begin
      timeout_status_flag_ff <= 1'b1;
      powerdown_status_flag_ff <= 1'b0;
    end
  end

  // One-cycle pulse so the watchdog counter and prescaler restart together
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_clear_ff <= 1'b0;
    end else begin
      wdt_clear_ff <= sleep_op;
    end
  end

  // Entering sleep wins over a simultaneous wake so the request is not lost
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_run_ff <= 1'b1;
    end else if (sleep_op) begin
      osc_run_ff <= 1'b0;
    end else if (wake_hit) begin
      osc_run_ff <= 1'b1;
    end
  end

  assign avs_readdata = readdata_ff;
  assign avs_waitrequest = wait_ff;
  assign osc_run = osc_run_ff;
  assign wdt_clear = wdt_clear_ff;

endmodule

`default_nettype wire

// file: src/sas_file_ram.sv
// File register memory with registered read data
`default_nettype none

module sas_file_ram #(
  parameter int DATA_W = 8,
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [AW-1:0] addr,
  input wire logic we,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] rdata_ff;

  // ==========================================================================
  // Storage; not reset, contents are undefined until written like real RAM
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // Read-before-write: a read-modify-write sees the old value
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= mem[addr];
    end
  end

  assign rdata = rdata_ff;

endmodule

`default_nettype wire

// file: src/sas_params.svh
// Constants for the subtract-and-sleep execution block: offsets, fields, resets, opcodes
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH

// ==========================================================================
// Register byte offsets on the Avalon-MM slave
`define SAS_OFS_ACC 10'h000
`define SAS_OFS_STATUS 10'h004
`define SAS_OFS_INSTR 10'h008
`define SAS_OFS_WAKE 10'h00C
`define SAS_OFS_FILE 10'h200

// ==========================================================================
// Status register bit positions
`define SAS_ST_CARRY 0
`define SAS_ST_NIBBLE 1
`define SAS_ST_ZERO 2
`define SAS_ST_PDOWN 3
`define SAS_ST_TOUT 4
`define SAS_ST_ASLEEP 5

// ==========================================================================
// Reset values
`define SAS_RST_ACC 8'h00
`define SAS_RST_TOUT 1'h1
`define SAS_RST_PDOWN 1'h1
`define SAS_RST_INSTR 14'h0000

// ==========================================================================
// Opcode patterns
`define SAS_OPC_SUBL 5'h1E
`define SAS_OPC_SUBF 6'h02
`define SAS_OPC_SLEEP 14'h0063

`endif

// file: src/sas_pkg.sv
// Types shared by the subtract-and-sleep execution block
`default_nettype none

package sas_pkg;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [1:0] {
    sas_st_idle,
    sas_st_bus_rd,
    sas_st_op_ex
  } sas_state_t;

endpackage

`default_nettype wire

// file: verification/sas_exec_bench.sv
// Self-checking bench for the subtract-and-sleep block
`default_nettype none
`include "sas_params.svh"

module sas_exec_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic wake_req = 1'h0;
  logic osc_run;
  logic wdt_clear;
  int error_cnt = 0;
  int n_tests = 0;
  int wdt_cnt = 0;
  logic [31:0] q;
  logic [9:0] fa;
  logic [13:0] ins;
  // ======
  // Subtraction cases: file op, dest, acc, minuend, result, carry
  typedef struct {logic f; logic d; logic [7:0] w; logic [7:0] m;
                  logic [7:0] r; logic c;} sas_row_t;
  sas_row_t rows [8] = '{
    '{1'h0, 1'h0, 8'h01, 8'h02, 8'h01, 1'h1},
    '{1'h0, 1'h0, 8'h02, 8'h02, 8'h00, 1'h1},
    '{1'h0, 1'h0, 8'h03, 8'h02, 8'hFF, 1'h0},
    '{1'h0, 1'h0, 8'hFF, 8'h00, 8'h01, 1'h0},
    '{1'h1, 1'h1, 8'h02, 8'h03, 8'h01, 1'h1},
    '{1'h1, 1'h1, 8'h02, 8'h02, 8'h00, 1'h1},
    '{1'h1, 1'h1, 8'h02, 8'h01, 8'hFF, 1'h0},
    '{1'h1, 1'h0, 8'h01, 8'h80, 8'h7F, 1'h1}};

  sas_exec sas_exec_inst (.clk, .arst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .wake_req,
    .osc_run, .wdt_clear);

  // 50 MHz core clock
  always #10 clk = ~clk;

  // Count watchdog clear pulses seen
  always @(posedge clk) begin
    if (wdt_clear === 1'h1) begin
      wdt_cnt <= wdt_cnt + 1;
    end
  end

  task automatic wrap_up;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 20);
    r = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (avs_waitrequest !== 1'h0) begin
      chk("bus answer", 32'h1, 32'h0);
      wrap_up();
    end
  endtask

  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      fa = 10'h200 + 10'(i * 68);
      ins = rows[i].f ? {6'h02, rows[i].d, 7'(i * 17)} : {6'h3C, rows[i].m};
      bus(1'h1, `SAS_OFS_ACC, 32'(rows[i].w), q);
      bus(1'h1, fa, 32'(rows[i].m), q);
      bus(1'h1, `SAS_OFS_INSTR, 32'(ins), q);
      bus(1'h0, (rows[i].f && rows[i].d) ? fa : `SAS_OFS_ACC, 32'h0, q);
      chk("result", q, 32'(rows[i].r));
      bus(1'h0, rows[i].d ? `SAS_OFS_ACC : fa, 32'h0, q);
      chk("other", q, 32'(rows[i].d ? rows[i].w : rows[i].m));
      bus(1'h0, `SAS_OFS_STATUS, 32'h0, q);
      chk("carry", 32'(q[0]), 32'(rows[i].c));
    end
    // Mid-run reset, then flags back at their reset levels
    arst_n <= 1'h0;
    repeat (3) @(posedge clk);
    arst_n <= 1'h1;
    bus(1'h0, `SAS_OFS_STATUS, 32'h0, q);
    chk("status reset", q, 32'h18);
    // Sleep, then an instruction while asleep must not execute
    bus(1'h1, `SAS_OFS_INSTR, 32'h63, q);
    repeat (3) @(posedge clk);
    chk("osc halted", 32'(osc_run), 32'h0);
    chk("wdt pulses", 32'(wdt_cnt), 32'h1);
    bus(1'h0, `SAS_OFS_STATUS, 32'h0, q);
    chk("status sleep", q, 32'h30);
    bus(1'h1, `SAS_OFS_INSTR, 32'h3C05, q);
    bus(1'h0, `SAS_OFS_ACC, 32'h0, q);
    chk("acc asleep", q, 32'h0);
    // Wake by pin, then sleep again and wake by register
    wake_req <= 1'h1;
    @(posedge clk);
    wake_req <= 1'h0;
    @(posedge clk);
    chk("wake pin", 32'(osc_run), 32'h1);
    bus(1'h1, `SAS_OFS_INSTR, 32'h63, q);
    bus(1'h1, `SAS_OFS_WAKE, 32'h1, q);
    @(posedge clk);
    chk("wake reg", 32'(osc_run), 32'h1);
    chk("wdt pulses", 32'(wdt_cnt), 32'h2);
    // Status write: bits 2..0 take the data, bits 5..3 stay read-only
    bus(1'h1, `SAS_OFS_STATUS, 32'h3F, q);
    bus(1'h0, `SAS_OFS_STATUS, 32'h0, q);
    chk("status write", q, 32'h17);
    // Instruction write without both low byte lanes must be ignored
    avs_byteenable <= 4'h1;
    bus(1'h1, `SAS_OFS_INSTR, 32'h63, q);
    avs_byteenable <= 4'hF;
    @(posedge clk);
    chk("partial lanes", 32'(osc_run), 32'h1);
    bus(1'h0, `SAS_OFS_INSTR, 32'h0, q);
    chk("instr kept", q, 32'h63);
    // Unmapped place reads zero
    bus(1'h0, 10'h010, 32'h0, q);
    chk("unmapped", q, 32'h0);
    wrap_up();
  end
endmodule

`default_nettype wire

// file: verification/sas_exec_properties.sv
// Port checker for the subtract-and-sleep block
`default_nettype none
`include "sas_params.svh"

module sas_exec_properties (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic wake_req,
  input wire logic osc_run,
  input wire logic wdt_clear
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ======
  // Accepted writes, decoded once
  logic wr_done;
  logic ins_ok;
  logic sleep_go;
  logic subf_go;
  logic wake_wr;
  assign wr_done = avs_write && !avs_waitrequest;
  assign ins_ok = wr_done && avs_address == `SAS_OFS_INSTR && avs_byteenable[1:0] == 2'h3;
  assign sleep_go = ins_ok && osc_run && avs_writedata[13:0] == `SAS_OPC_SLEEP;
  assign subf_go = ins_ok && osc_run && avs_writedata[13:8] == `SAS_OPC_SUBF;
  assign wake_wr = wr_done && avs_address == `SAS_OFS_WAKE && avs_writedata[0];
  // ======
  // Assertions
  AST_SLEEP_HALT: assert property (sleep_go |=> !osc_run)
    else $error("oscillator still running after sleep");
  AST_WDT_PULSE: assert property (sleep_go |=> ##[0:1] wdt_clear)
    else $error("no watchdog clear after sleep");
  AST_WDT_ONE: assert property (wdt_clear |=> !wdt_clear)
    else $error("watchdog clear longer than one cycle");
  AST_WAKE: assert property (!osc_run && wake_req |=> osc_run)
    else $error("no wake on request");
  AST_STAY: assert property (!osc_run && !wake_req && !wake_wr |=> !osc_run)
    else $error("oscillator restarted without wake");
  AST_WAKE_REG: assert property (!osc_run && wake_wr && avs_byteenable[0] |=> osc_run)
    else $error("no wake on register write");
  AST_ACC_BYTE: assert property (avs_read && !avs_waitrequest &&
    avs_address == `SAS_OFS_ACC |-> avs_readdata[31:8] == 24'h0)
    else $error("accumulator read upper bits not zero");
  AST_SUBF_HOLD: assert property (subf_go |=> avs_waitrequest [*2])
    else $error("bus answered during file subtraction");
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  // Main scenarios
  cover property (sleep_go);
  cover property (subf_go);
  cover property (wake_wr);
endmodule

bind sas_exec sas_exec_properties sas_exec_properties_inst (.clk, .arst_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .wake_req, .osc_run, .wdt_clear);

`default_nettype wire
